// ==== hdl/stream_ready_latency_adapter.sv ====
// ready/valid timing adapter with its data-path buffer
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstN,
  // fill side
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  // drain side
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData,
  // occupancy
  output logic [CNT_W-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CNT_W-1:0] cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;

  assign wrReady = (s_q.cnt != FULL);
  assign rdValid = (s_q.cnt != '0);
  assign rdData = s_q.mem[s_q.rdPtr];
  assign count = s_q.cnt;
  assign push = wrValid && wrReady;
  assign pop = rdValid && rdReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = wrData;
      s_d.wrPtr = (s_q.wrPtr == LAST) ? '0 : s_q.wrPtr + 1'b1;
    end
    if (pop) begin
      s_d.rdPtr = (s_q.rdPtr == LAST) ? '0 : s_q.rdPtr + 1'b1;
    end
    s_d.cnt = s_q.cnt + CNT_W'(push) - CNT_W'(pop);
  end

  // storage, pointers and count all clear on reset
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  fifoBound_a: assert property ( // RQ14
    @(posedge mclk) disable iff (!rstN) s_q.cnt <= FULL)
    else $error("buffer count beyond depth");
endmodule

module stream_ready_latency_adapter
  import stream_adapter_pkg::*;
#(
  parameter bit IN_HAS_READY = 1'b1,
  parameter bit IN_HAS_VALID = 1'b1,
  parameter int IN_READY_LATENCY = 2,
  parameter bit OUT_HAS_READY = 1'b1,
  parameter bit OUT_HAS_VALID = 1'b1,
  parameter int OUT_READY_LATENCY = 1,
  parameter int CHANNEL_WIDTH = 4,
  parameter int MAX_CHANNEL = 15,
  parameter int BITS_PER_SYMBOL = 8,
  parameter int SYMBOLS_PER_BEAT = 4,
  parameter bit HAS_PACKETS = 1'b1,
  parameter bit HAS_EMPTY = 1'b1,
  parameter int ERROR_WIDTH = 2,
  localparam int DATA_W = BITS_PER_SYMBOL * SYMBOLS_PER_BEAT,
  localparam int CH_W = (CHANNEL_WIDTH > 0) ? CHANNEL_WIDTH : 1,
  localparam int EMPTY_W =
    (SYMBOLS_PER_BEAT > 1) ? $clog2(SYMBOLS_PER_BEAT) : 1,
  localparam int ERR_W = (ERROR_WIDTH > 0) ? ERROR_WIDTH : 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // input side, driven by the upstream source
  input wire logic inValid,
  output logic inReady,
  input wire logic [DATA_W-1:0] inData,
  input wire logic [CH_W-1:0] inChannel,
  input wire logic inSop,
  input wire logic inEop,
  input wire logic [EMPTY_W-1:0] inEmpty,
  input wire logic [ERR_W-1:0] inError,
  // output side, driving the downstream sink
  output logic outValid,
  input wire logic outReady,
  output logic [DATA_W-1:0] outData,
  output logic [CH_W-1:0] outChannel,
  output logic outSop,
  output logic outEop,
  output logic [EMPTY_W-1:0] outEmpty,
  output logic [ERR_W-1:0] outError,
  // status
  output logic dataLost
);
  localparam int PW = DATA_W + CH_W + 2 + EMPTY_W + ERR_W;
  localparam int OUT_IDX = (OUT_READY_LATENCY > 0) ? OUT_READY_LATENCY - 1 : 0;
  localparam int DIFF = OUT_READY_LATENCY - IN_READY_LATENCY;
  localparam int DIFF_IDX = (DIFF > 0) ? DIFF - 1 : 0;
  localparam int IN_IDX = IN_READY_LATENCY;
  // zero-latency sink with ready: a beat waits on the wire until taken
  localparam bit HOLD_MODE = OUT_HAS_READY && (OUT_READY_LATENCY == 0);
  localparam bit USE_CH = (CHANNEL_WIDTH > 0);
  localparam bit USE_EMPTY = HAS_PACKETS && HAS_EMPTY && (SYMBOLS_PER_BEAT > 1);
  localparam bit USE_ERR = (ERROR_WIDTH > 0);

  typedef struct packed {
    logic [HIST_W-2:0] outHist;
    logic [HIST_W-2:0] inHist;
    logic inReady;
    logic outValid;
    logic [PW-1:0] outWord;
    logic lost;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] rstPipe_q;
  logic rstSyncN;
  logic [HIST_W-1:0] outAgo;
  logic [HIST_W-1:0] inAgo;
  logic inBeat;
  logic [PW-1:0] inWord;
  logic fifoWrReady;
  logic fifoRdValid;
  logic fifoRdReady;
  logic [PW-1:0] fifoRdData;
  logic [FIFO_CNT_W-1:0] fifoCount;

  // two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= RESET_SYNC;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];

  // ago[k] is the ready seen k cycles back, ago[0] the present one
  assign outAgo = {s_q.outHist, outReady};
  assign inAgo = {s_q.inHist, s_q.inReady};

  // without valid, a beat is implied by the ready cycle latency ago
  always_comb begin
    if (IN_HAS_VALID) begin
      inBeat = inValid;
    end else if (IN_HAS_READY) begin
      inBeat = inAgo[IN_IDX]; // RQ1
    end else begin
      inBeat = 1'b1; // RQ2
    end
  end

  // disabled sideband is forced to zero so it never carries noise
  assign inWord = {
    inData, // RQ11
    USE_CH ? inChannel : {CH_W{1'b0}}, // RQ5
    HAS_PACKETS ? inSop : 1'b0, // RQ7
    HAS_PACKETS ? inEop : 1'b0,
    USE_EMPTY ? inEmpty : {EMPTY_W{1'b0}}, // RQ8
    USE_ERR ? inError : {ERR_W{1'b0}} // RQ9
  };

  // drain permission of the buffer toward the sink
  always_comb begin
    if (!OUT_HAS_READY) begin
      fifoRdReady = 1'b1;
    end else if (HOLD_MODE) begin
      fifoRdReady = !s_q.outValid || outReady;
    end else begin
      fifoRdReady = outAgo[OUT_IDX]; // RQ1
    end
  end

  stream_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(FIFO_CNT_W)
  ) dataBuf (
    .mclk(mclk),
    .rstN(rstSyncN),
    .wrValid(inBeat),
    .wrReady(fifoWrReady),
    .wrData(inWord),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdData),
    .count(fifoCount)
  );

  always_comb begin
    int freeNext;
    freeNext = FIFO_DEPTH - int'(fifoCount)
      - int'(inBeat && fifoWrReady) + int'(fifoRdValid && fifoRdReady);
    s_d = s_q;
    s_d.outHist = {s_q.outHist[HIST_W-3:0], outReady};
    s_d.inHist = {s_q.inHist[HIST_W-3:0], s_q.inReady};
    // each side's ready option picks the ready scheme
    if (!IN_HAS_READY) begin // RQ4
      s_d.inReady = 1'b1;
    end else if (!OUT_HAS_READY) begin
      s_d.inReady = 1'b1; // RQ12
    end else if (DIFF > 0) begin
      s_d.inReady = outAgo[DIFF_IDX]; // RQ13
    end else begin
      // credits: every ready cycle still in flight may bring a beat
      s_d.inReady = freeNext >= IN_READY_LATENCY + 1; // RQ14
    end
    // the sink without valid takes every cycle, so valid only reports
    if (fifoRdReady) begin
      s_d.outValid = fifoRdValid; // RQ3
      if (fifoRdValid) begin
        s_d.outWord = fifoRdData; // RQ16
      end
    end else if (!HOLD_MODE) begin
      s_d.outValid = 1'b0; // RQ1
    end
    // a beat the buffer cannot take is gone; flag it one cycle later
    s_d.lost = inBeat && !fifoWrReady; // RQ15
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_q <= '0; // RQ17
      s_q.inReady <= RESET_READY;
      s_q.outValid <= RESET_VALID;
    end else begin
      s_q <= s_d;
    end
  end

  // error bits are not remapped here
  assign {outData, outChannel, outSop, outEop, outEmpty, outError} =
    s_q.outWord; // RQ10
  assign outValid = s_q.outValid;
  assign inReady = s_q.inReady;
  assign dataLost = s_q.lost;

  sequence lostBeat_s;
    inBeat && !fifoWrReady;
  endsequence

  sequence resetRelease_s;
    $rose(rstSyncN);
  endsequence

  lossFlag_a: assert property ( // RQ15
    @(posedge mclk) disable iff (!rstSyncN) lostBeat_s |=> dataLost)
    else $error("lost beat not flagged");

  noFalseLoss_a: assert property ( // RQ15
    @(posedge mclk) disable iff (!rstSyncN)
    dataLost |-> $past(inBeat) && !$past(fifoWrReady))
    else $error("loss flagged without a lost beat");

  cleanStart_a: assert property ( // RQ17
    @(posedge mclk)
    resetRelease_s |-> !outValid && !dataLost && fifoCount == '0)
    else $error("stale state after reset");

  channelRange_a: assert property ( // RQ6
    @(posedge mclk) disable iff (!rstSyncN)
    outValid && USE_CH |-> int'(outChannel) <= MAX_CHANNEL)
    else $error("channel above highest channel");

  zeroSideband_a: assert property ( // RQ9
    @(posedge mclk) disable iff (!rstSyncN)
    (!USE_ERR |-> outError == '0) and (!HAS_PACKETS |-> !outSop && !outEop))
    else $error("removed sideband not zero");

  generate
    if (IN_HAS_READY && !OUT_HAS_READY) begin : gTie
      readyTied_a: assert property ( // RQ12
        @(posedge mclk) disable iff (!rstSyncN) $past(rstSyncN) |-> inReady)
        else $error("source ready not held high");
    end
    if (IN_HAS_READY && OUT_HAS_READY && DIFF > 0) begin : gPipe
      readyDelay_a: assert property ( // RQ13
        @(posedge mclk) disable iff (!rstSyncN)
        $past(rstSyncN, HIST_W) |-> inReady == $past(outReady, DIFF))
        else $error("delayed ready mismatch");
    end
    // a cycle granted by ready must find room, whatever the source does
    if (IN_HAS_READY && OUT_HAS_READY && DIFF <= 0) begin : gCredit
      noOverflow_a: assert property ( // RQ14
        @(posedge mclk) disable iff (!rstSyncN) inAgo[IN_IDX] |-> fifoWrReady)
        else $error("credited cycle found the buffer full");
    end
    if (OUT_HAS_READY && OUT_READY_LATENCY > 0) begin : gLat
      outLatency_a: assert property ( // RQ1
        @(posedge mclk) disable iff (!rstSyncN)
        outValid |-> $past(outReady, OUT_READY_LATENCY))
        else $error("beat driven outside a ready cycle");
    end
    if (HOLD_MODE) begin : gHold
      beatHold_a: assert property ( // RQ16
        @(posedge mclk) disable iff (!rstSyncN)
        outValid && !outReady |=> outValid && $stable(s_q.outWord))
        else $error("unaccepted beat changed");
    end
  endgenerate
endmodule

`default_nettype wire

// ==== hdl/stream_adapter_pkg.sv ====
// constants shared by the stream ready-latency adapter
//
// Overview of operation
// [RQ1] Where a side has ready, its ready latency is the cycle count from ready high to when a valid beat may be driven.
// [RQ2] An input side without valid is treated as carrying a valid beat on every cycle it may carry one.
// [RQ3] An output side without valid obliges the sink to take every driven beat as valid in every cycle.
// [RQ4] Each side has its own backpressure option that decides whether that side has a ready signal.
// [RQ5] The channel width is a common parameter of at most eight bits; zero removes the channel signal.
// [RQ6] The highest channel number is a common parameter in the range zero to 255.
// [RQ7] With packet support both sides carry first-beat, last-beat and empty, passed along with their beat.
// [RQ8] Empty counts the unused symbols of the last beat of a packet and may be left out for one symbol per beat.
// [RQ9] The error width is a common parameter from zero to 31 bits; zero removes the error signal.
// [RQ10] Error bits pass straight through, so source and sink must give each error bit the same meaning.
// [RQ11] Bits per symbol and symbols per beat are common parameters that size the data of each beat.
// [RQ12] With ready at the source but none at the sink, the ready returned to the source is held at one.
// [RQ13] With a larger sink latency, ready is delayed by the latency difference so both sides see the same ready cycles.
// [RQ14] With a smaller sink latency, a buffer absorbs the beats the source still sends after ready falls.
// [RQ15] With no ready at the source but ready at the sink, a beat that cannot be taken raises a loss indication.
// [RQ16] All sideband and data travel unchanged and aligned with their beat from input to output.
// [RQ17] One clock serves all; reset empties the buffer and clears the pipeline so no stale beat appears.
package stream_adapter_pkg;

  // buffer in the data path
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CNT_W = 4;

  // ready history; latencies up to HIST_W-1 are supported
  localparam int HIST_W = 8;
  localparam int MAX_READY_LATENCY = 7;

  // sideband limits
  localparam int CHANNEL_WIDTH_MAX = 8;
  localparam int MAX_CHANNEL_LIMIT = 255;
  localparam int ERROR_WIDTH_MAX = 31;

  // reset values
  localparam logic RESET_READY = 1'b0;
  localparam logic RESET_VALID = 1'b0;
  localparam logic [1:0] RESET_SYNC = 2'b00;

endpackage

// ==== tb/stream_sink_model.sv ====
// downstream sink model with a ready latency of one cycle
`timescale 1ns/1ps
`default_nettype none
module stream_sink_model #(
  parameter int W = 42
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // stream from the adapter
  input wire logic outValid,
  input wire logic [W-1:0] outWord,
  output logic outReady,
  // backpressure request
  input wire logic stall
);
  logic [W-1:0] got[$];
  int lateBeats = 0;
  logic prevReady = 1'b0;
  // every valid cycle is taken, and a beat without ready one cycle back is counted as late
  always @(posedge mclk) begin
    if (outValid === 1'b1) begin
      if (prevReady !== 1'b1) lateBeats++;
      got.push_back(outWord);
    end
    prevReady <= outReady;
    outReady <= !stall && rst_n;
  end
endmodule
`default_nettype wire

// ==== tb/stream_ready_latency_adapter_tb.sv ====
// testbench for the stream ready-latency adapter
`timescale 1ns/1ps
`default_nettype none
module stream_ready_latency_adapter_tb;
  import stream_adapter_pkg::*;
  localparam int W = 42;
  logic mclk = 1'b0;
  logic rst_n;
  logic inValid = 1'b0;
  logic [W-1:0] inWord = '0;
  logic inReady, outValid, outReady, dataLost;
  wire [W-1:0] outWord;
  logic holdStall = 1'b0;
  logic chop = 1'b0;
  logic stall = 1'b0;
  logic rdyOld = 1'b0;
  logic [2:0] cyc = 3'h0;
  logic [W-1:0] expQ[$];
  int n_errors = 0;
  int tests_run = 0;
  int lostSeen = 0;
  logic freeReady, freeValid, freeLost;
  int freeBeats = 0;
  int freeLosses = 0;

  always #50 mclk = ~mclk;

  stream_ready_latency_adapter dut (
    .mclk(mclk), .rst_n(rst_n),
    .inValid(inValid), .inReady(inReady), .inData(inWord[41:10]),
    .inChannel(inWord[9:6]), .inSop(inWord[5]), .inEop(inWord[4]),
    .inEmpty(inWord[3:2]), .inError(inWord[1:0]),
    .outValid(outValid), .outReady(outReady), .outData(outWord[41:10]),
    .outChannel(outWord[9:6]), .outSop(outWord[5]), .outEop(outWord[4]),
    .outEmpty(outWord[3:2]), .outError(outWord[1:0]), .dataLost(dataLost)
  );

  stream_sink_model #(.W(W)) sink (
    .mclk(mclk), .rst_n(rst_n), .outValid(outValid), .outWord(outWord),
    .outReady(outReady), .stall(stall)
  );

  // second adapter whose sink has no ready; it shares the source stimulus
  stream_ready_latency_adapter #(.OUT_HAS_READY(1'b0)) dutFree (
    .mclk(mclk), .rst_n(rst_n),
    .inValid(inValid), .inReady(freeReady), .inData(inWord[41:10]),
    .inChannel(inWord[9:6]), .inSop(inWord[5]), .inEop(inWord[4]),
    .inEmpty(inWord[3:2]), .inError(inWord[1:0]),
    .outValid(freeValid), .outReady(1'b0), .outData(), .outChannel(),
    .outSop(), .outEop(), .outEmpty(), .outError(), .dataLost(freeLost)
  );

  // rdyOld holds inReady of one cycle back at each edge
  always @(posedge mclk) begin
    rdyOld <= inReady;
    cyc <= cyc + 3'h1;
    stall <= holdStall || (chop && cyc < 3'h3);
    if (dataLost === 1'b1) lostSeen++;
    if (freeValid === 1'b1) freeBeats++;
    if (freeLost === 1'b1) freeLosses++;
  end

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // channel stays within 15; empty only on the last beat
  function automatic logic [W-1:0] mk(input int i);
    logic [7:0] b;
    b = 8'(i);
    mk = {{4{b ^ 8'h5a}}, b[3:0], b[1:0] == 2'h0, b[1:0] == 2'h3,
      (b[1:0] == 2'h3) ? b[3:2] : 2'h0, b[5:4]};
  endfunction

  // obey=0 ignores the input ready latency on purpose
  task automatic send(input logic [W-1:0] w, input bit obey);
    int guard;
    guard = 0;
    @(posedge mclk);
    while (obey && rdyOld !== 1'b1 && guard < 200) begin
      inValid <= 1'b0;
      @(posedge mclk);
      guard++;
    end
    check(W'(guard < 200), W'(1));
    inValid <= 1'b1;
    inWord <= w;
    expQ.push_back(w);
  endtask

  // released payload shows the inverse so stale data cannot match
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      inValid <= 1'b0;
      inWord <= ~inWord;
    end
  endtask

  task automatic drain();
    int guard;
    guard = 0;
    while (sink.got.size() + lostSeen < expQ.size() && guard < 300) begin
      @(posedge mclk);
      guard++;
    end
    idle(4);
    check(W'(sink.got.size() + lostSeen), W'(expQ.size()));
    foreach (sink.got[k]) check(sink.got[k], expQ[k]);
    expQ.delete();
    sink.got.delete();
  endtask

  initial begin
    #500000;
    n_errors++;
    finish_test();
  end

  initial begin
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    idle(4);
    chop <= 1'b1;
    for (int i = 0; i < 24; i++) send(mk(i), 1'b1);
    idle(1);
    drain();
    check(W'(lostSeen), '0);
    chop <= 1'b0;
    lostSeen = 0;
    // overrun: a stalled sink and a source that ignores ready
    holdStall <= 1'b1;
    idle(10);
    for (int i = 0; i < 12; i++) send(mk(100 + i), 1'b0);
    idle(3);
    check(W'(inReady), '0);
    check(W'(lostSeen), W'(12 - FIFO_DEPTH));
    check(W'(freeReady), W'(1));
    holdStall <= 1'b0;
    drain();
    check(W'(freeBeats), W'(24 + 12));
    check(W'(freeLosses), '0);
    // reset in mid-stream leaves no stale beat
    holdStall <= 1'b1;
    idle(3);
    for (int i = 0; i < 5; i++) send(mk(200 + i), 1'b1);
    idle(2);
    rst_n <= 1'b0;
    repeat (3) begin
      @(posedge mclk);
      check(W'({inReady, outValid, dataLost, freeReady, freeValid}), '0);
    end
    rst_n <= 1'b1;
    holdStall <= 1'b0;
    expQ.delete();
    idle(30);
    check(W'(sink.got.size()), '0);
    check(W'(sink.lateBeats), '0);
    finish_test();
  end
endmodule
`default_nettype wire
